// ---- hw/dmm_addr_map.sv ----
// Data memory address map: bank select, two pointer/port pairs,
// banked and linear RAM views and a read-only byte view of flash.
// Assumes the core issues at most one access at a time and waits for
// the done pulse, and that flash answers in the same cycle its request pulse is high.

`timescale 1ns/1ps

module dmm_addr_map #(
   // Number of banks that actually have general purpose RAM.
   parameter int GPR_BANKS = 31
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_acc_req,
   input wire dmm_pkg::dmm_req_t i_acc,
   input wire logic [dmm_pkg::FLASH_DW-1:0] i_flash_rdata,
   output logic o_acc_done,
   output logic [7:0] o_acc_rdata,
   output logic o_busy,
   output logic o_flash_req,
   output logic [dmm_pkg::FLASH_AW-1:0] o_flash_addr,
   output logic [dmm_pkg::BANK_W-1:0] o_bank_sel
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int GPR_DEPTH = GPR_BANKS * dmm_pkg::GPR_BYTES;

   // Registered state and its next value.
   dmm_pkg::dmm_regs_t cur_q;
   dmm_pkg::dmm_regs_t nxt_d;

   // Storage; arrays carry no reset, contents are undefined at power up.
   // Banks at or above GPR_BANKS get no storage at all; their slots
   // fall through to the zero answer rather than wrapping onto RAM.
   logic [7:0] gpr_mem [GPR_DEPTH];
   logic [7:0] com_mem [dmm_pkg::COMMON_BYTES];

   // Pointer chosen by the port offset, and its window decode.
   logic [15:0] ptr;
   logic via_ptr;
   logic is_flash;
   logic is_lin;
   logic [15:0] lin_ofs;
   // Effective 12-bit banked address for non-linear accesses.
   logic [dmm_pkg::ADDR_W-1:0] eff;
   logic [dmm_pkg::BANK_W-1:0] eff_bank;
   logic [dmm_pkg::OFS_W-1:0] eff_ofs;
   logic eff_ok;
   // Resolved target kind flags.
   logic hit_core;
   logic hit_gpr;
   logic hit_com;
   // RAM index of the hit, bank and in-bank offset.
   logic [15:0] gpr_bank;
   logic [15:0] gpr_rem;
   logic [15:0] gpr_idx;
   logic [3:0] com_idx;
   logic [7:0] rd_val;
   logic take;
   logic mem_we;

   // ----------------------------------------------------------------
   // Address resolution
   // ----------------------------------------------------------------
   // The two port offsets redirect the access through a pointer; any
   // other offset is a direct access in the selected bank.
   always_comb
   begin
      via_ptr = (i_acc.ofs == dmm_pkg::OFS_PORT0) ||
                (i_acc.ofs == dmm_pkg::OFS_PORT1);
      ptr = (i_acc.ofs == dmm_pkg::OFS_PORT1) ? cur_q.ptr1 : cur_q.ptr0;
      is_flash = via_ptr && ptr[dmm_pkg::FLASH_BIT];
      is_lin = via_ptr && !is_flash && (ptr >= dmm_pkg::LIN_BASE) &&
               (ptr <= dmm_pkg::LIN_LAST);
      lin_ofs = ptr - dmm_pkg::LIN_BASE;
      if (via_ptr)
      begin
         // Pointers in the banked window carry their own bank bits,
         // so the bank select register plays no part here.
         eff = ptr[dmm_pkg::ADDR_W-1:0];
         eff_ok = (ptr < dmm_pkg::BANKED_TOP);
      end
      else
      begin
         // Direct access takes the bank last written to bank select.
         eff = {cur_q.bank_sel, i_acc.ofs};
         eff_ok = 1'b1;
      end
      // Upper five bits name the bank, lower seven the location.
      eff_bank = eff[dmm_pkg::ADDR_W-1:dmm_pkg::OFS_W];
      eff_ofs = eff[dmm_pkg::OFS_W-1:0];
   end

   // ----------------------------------------------------------------
   // Target decode
   // ----------------------------------------------------------------
   // Every bank holds the same layout; the special function slots are
   // not served by this block and fall through to the zero answer.
   always_comb
   begin
      hit_core = 1'b0;
      hit_gpr = 1'b0;
      hit_com = 1'b0;
      gpr_bank = 16'h0000;
      gpr_rem = 16'h0000;
      com_idx = eff_ofs[3:0];
      if (is_lin)
      begin
         // Linear offsets split into a bank and a place within that
         // bank's 80 bytes, so the last byte of one bank runs straight
         // into the first byte of the next and common RAM never shows.
         gpr_bank = lin_ofs / 16'(dmm_pkg::GPR_BYTES);
         gpr_rem = lin_ofs % 16'(dmm_pkg::GPR_BYTES);
         hit_gpr = 1'b1;
      end
      else if (!is_flash && eff_ok)
      begin
         if (eff_ofs < dmm_pkg::CORE_END)
         begin
            // Core registers appear at the same offsets in all banks.
            hit_core = 1'b1;
         end
         else if (eff_ofs >= dmm_pkg::COMMON_BASE)
         begin
            // Common RAM is one 16-byte block seen from every bank.
            hit_com = 1'b1;
         end
         else if (eff_ofs >= dmm_pkg::GPR_BASE)
         begin
            gpr_bank = 16'(eff_bank);
            gpr_rem = 16'(eff_ofs - dmm_pkg::GPR_BASE);
            hit_gpr = 1'b1;
         end
         else
         begin
            // Special function slot, left to other blocks.
            hit_core = 1'b0;
         end
      end
      else
      begin
         // Flash or an unmapped pointer; no RAM or register is hit.
         hit_core = 1'b0;
      end
      gpr_idx = 16'(gpr_bank * 16'(dmm_pkg::GPR_BYTES) + gpr_rem);
      // Banks without RAM behind them answer as unimplemented.
      if (gpr_bank >= 16'(GPR_BANKS))
      begin
         hit_gpr = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read data mux
   // ----------------------------------------------------------------
   // Anything not decoded above reads as zero, including the port
   // offsets reached through a pointer, which would otherwise recurse.
   always_comb
   begin
      rd_val = 8'h00;
      if (hit_gpr)
      begin
         rd_val = gpr_mem[gpr_idx[$clog2(GPR_DEPTH)-1:0]];
      end
      else if (hit_com)
      begin
         rd_val = com_mem[com_idx];
      end
      else if (hit_core)
      begin
         case (eff_ofs)
            dmm_pkg::OFS_PTR0_LO: rd_val = cur_q.ptr0[7:0];
            dmm_pkg::OFS_PTR0_HI: rd_val = cur_q.ptr0[15:8];
            dmm_pkg::OFS_PTR1_LO: rd_val = cur_q.ptr1[7:0];
            dmm_pkg::OFS_PTR1_HI: rd_val = cur_q.ptr1[15:8];
            dmm_pkg::OFS_BANK_SEL: rd_val = 8'(cur_q.bank_sel);
            default: rd_val = 8'h00;
         endcase
      end
      else
      begin
         rd_val = 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer and register updates
   // ----------------------------------------------------------------
   // A request is only taken while idle; while a flash fetch is in
   // flight the busy flag tells the core to hold off.
   // A request that arrives on the edge ending a flash fetch is dropped
   // without notice; the core must wait for done before asking again.
   assign take = i_acc_req && (cur_q.st == dmm_pkg::DMM_IDLE);
   // Flash targets never reach the write path.
   assign mem_we = take && i_acc.wr && !is_flash;

   always_comb
   begin
      nxt_d = cur_q;
      nxt_d.done = 1'b0;
      nxt_d.flash_req = 1'b0;
      case (cur_q.st)
         dmm_pkg::DMM_IDLE:
         begin
            if (take && is_flash)
            begin
               // Flash costs one extra cycle: request now, answer next.
               nxt_d.st = dmm_pkg::DMM_FLASH;
               nxt_d.flash_req = 1'b1;
               nxt_d.flash_addr = ptr[dmm_pkg::FLASH_AW-1:0];
               nxt_d.busy = 1'b1;
            end
            else if (take)
            begin
               nxt_d.done = 1'b1;
               nxt_d.rdata = i_acc.wr ? 8'h00 : rd_val;
               if (i_acc.wr && hit_core)
               begin
                  case (eff_ofs)
                     dmm_pkg::OFS_PTR0_LO: nxt_d.ptr0[7:0] = i_acc.wdata;
                     dmm_pkg::OFS_PTR0_HI: nxt_d.ptr0[15:8] = i_acc.wdata;
                     dmm_pkg::OFS_PTR1_LO: nxt_d.ptr1[7:0] = i_acc.wdata;
                     dmm_pkg::OFS_PTR1_HI: nxt_d.ptr1[15:8] = i_acc.wdata;
                     dmm_pkg::OFS_BANK_SEL:
                        nxt_d.bank_sel =
                           i_acc.wdata[dmm_pkg::BANK_W-1:0];
                     default: nxt_d.done = 1'b1;
                  endcase
               end
            end
            else
            begin
               nxt_d.busy = 1'b0;
            end
         end
         dmm_pkg::DMM_FLASH:
         begin
            // Only the low byte of the 14-bit word is visible; a write
            // that landed here completes without touching flash.
            // The write flag is not kept across the fetch, so a write
            // aimed at flash still answers with the fetched byte.
            nxt_d.rdata = i_flash_rdata[7:0];
            nxt_d.done = 1'b1;
            nxt_d.busy = 1'b0;
            nxt_d.st = dmm_pkg::DMM_IDLE;
         end
         default:
         begin
            nxt_d.st = dmm_pkg::DMM_IDLE;
            nxt_d.busy = 1'b0;
         end
      endcase
   end

   // State register; pointers and bank select start at zero.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cur_q.st <= dmm_pkg::DMM_IDLE;
         cur_q.bank_sel <= dmm_pkg::BANK_RST;
         cur_q.ptr0 <= dmm_pkg::PTR_RST;
         cur_q.ptr1 <= dmm_pkg::PTR_RST;
         cur_q.rdata <= 8'h00;
         cur_q.done <= 1'b0;
         cur_q.busy <= 1'b0;
         cur_q.flash_req <= 1'b0;
         cur_q.flash_addr <= 15'h0000;
      end
      else
      begin
         cur_q <= nxt_d;
      end
   end

   // ----------------------------------------------------------------
   // RAM write ports
   // ----------------------------------------------------------------
   // Direct and pointer writes share one port; the same decode is used
   // for reads so both views stay aliased onto the same bytes.
   // The linear window has no storage of its own for the same reason:
   // a second copy could drift from the banked bytes it mirrors.
   always_ff @(posedge i_sys_clk)
   begin
      if (mem_we && hit_gpr)
      begin
         gpr_mem[gpr_idx[$clog2(GPR_DEPTH)-1:0]] <= i_acc.wdata;
      end
      if (mem_we && hit_com)
      begin
         com_mem[com_idx] <= i_acc.wdata;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign o_acc_done = cur_q.done;
   assign o_acc_rdata = cur_q.rdata;
   assign o_busy = cur_q.busy;
   assign o_flash_req = cur_q.flash_req;
   assign o_flash_addr = cur_q.flash_addr;
   assign o_bank_sel = cur_q.bank_sel;

endmodule : dmm_addr_map

// ---- hw/dmm_pkg.sv ----
// Constants, types and carriers shared by the data memory address map.
// Assumes a single 250 MHz system clock and one processor-side requester.

package dmm_pkg;

   // ----------------------------------------------------------------
   // Geometry of the banked space
   // ----------------------------------------------------------------
   localparam int BANK_W = 5;
   localparam int OFS_W = 7;
   localparam int ADDR_W = 12;
   localparam int NUM_BANKS = 32;
   localparam int BANK_BYTES = 128;
   localparam logic [OFS_W-1:0] CORE_END = 7'h0C;
   localparam logic [OFS_W-1:0] GPR_BASE = 7'h20;
   localparam logic [OFS_W-1:0] COMMON_BASE = 7'h70;
   localparam int GPR_BYTES = 80;
   localparam int COMMON_BYTES = 16;

   // ----------------------------------------------------------------
   // Core register offsets inside every bank
   // ----------------------------------------------------------------
   localparam logic [OFS_W-1:0] OFS_PORT0 = 7'h00;
   localparam logic [OFS_W-1:0] OFS_PORT1 = 7'h01;
   localparam logic [OFS_W-1:0] OFS_PTR0_LO = 7'h04;
   localparam logic [OFS_W-1:0] OFS_PTR0_HI = 7'h05;
   localparam logic [OFS_W-1:0] OFS_PTR1_LO = 7'h06;
   localparam logic [OFS_W-1:0] OFS_PTR1_HI = 7'h07;
   localparam logic [OFS_W-1:0] OFS_BANK_SEL = 7'h08;

   // ----------------------------------------------------------------
   // Pointer space windows
   // ----------------------------------------------------------------
   localparam logic [15:0] LIN_BASE = 16'h2000;
   localparam logic [15:0] LIN_LAST = 16'h29AF;
   localparam logic [15:0] BANKED_TOP = 16'h1000;
   localparam int FLASH_BIT = 15;
   localparam int FLASH_AW = 15;
   localparam int FLASH_DW = 14;

   // Reset values of the pointer and bank select registers.
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [BANK_W-1:0] BANK_RST = 5'h00;

   // Sequencer states: a normal access ends in one cycle, flash in two.
   typedef enum logic [0:0] {
      DMM_IDLE,
      DMM_FLASH
   } dmm_state_e_t;

   // One access from the core: offset, direction and write data.
   typedef struct packed {
      logic wr;
      logic [OFS_W-1:0] ofs;
      logic [7:0] wdata;
   } dmm_req_t;

   // Whole registered state of the address map.
   typedef struct packed {
      dmm_state_e_t st;
      logic [BANK_W-1:0] bank_sel;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
      logic [7:0] rdata;
      logic done;
      logic busy;
      logic flash_req;
      logic [FLASH_AW-1:0] flash_addr;
   } dmm_regs_t;

endpackage : dmm_pkg

// ---- testbench/dmm_flash_model.sv ----
// Stand-in for the program flash behind the data memory address map.
// Assumes one fetch pulse per flash access, answered in that same cycle.
`timescale 1ns/1ps
module dmm_flash_model (
   input wire logic i_sys_clk,
   input wire logic i_req,
   input wire logic [dmm_pkg::FLASH_AW-1:0] i_addr,
   output logic [dmm_pkg::FLASH_DW-1:0] o_rdata
);
   // Outside a fetch the word flips each cycle between 14'h2AAA and 14'h1556, so stale data changes from cycle to cycle.
   logic [13:0] junk_q = 14'h2AAA;
   always @(posedge i_sys_clk)
   begin
      junk_q <= ~junk_q + 14'h0001;
   end
   // The word is a fixed scramble of its own address.
   assign o_rdata = i_req ? (i_addr[13:0] ^ 14'h1A5C) : junk_q;
endmodule : dmm_flash_model

// ---- testbench/dmm_addr_map_assertions.sv ----
// Timing checks on the ports of the data memory address map.
// Assumes it is bound to the map and sees only its ports.
`timescale 1ns/1ps
module dmm_addr_map_assertions #(
   parameter int GPR_BANKS = 31
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_acc_req,
   input wire dmm_pkg::dmm_req_t i_acc,
   input wire logic [dmm_pkg::FLASH_DW-1:0] i_flash_rdata,
   input wire logic o_acc_done,
   input wire logic [7:0] o_acc_rdata,
   input wire logic o_busy,
   input wire logic o_flash_req,
   input wire logic [dmm_pkg::FLASH_AW-1:0] o_flash_addr,
   input wire logic [dmm_pkg::BANK_W-1:0] o_bank_sel
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   // A request counts only while no flash fetch is in flight.
   wire take = i_acc_req && !o_busy;
   property p_flash_done;
      o_flash_req |-> o_busy ##1 (o_acc_done && !o_busy);
   endproperty
   a_flash_done: assert property (p_flash_done)
      else $error("flash access did not end after one extra cycle");
   property p_flash_cause;
      o_flash_req |-> $past(take) && ($past(i_acc.ofs) <= 7'h01);
   endproperty
   a_flash_cause: assert property (p_flash_cause)
      else $error("flash fetch without a port access");
   property p_flash_byte;
      o_flash_req |=> o_acc_rdata == $past(i_flash_rdata[7:0]);
   endproperty
   a_flash_byte: assert property (p_flash_byte)
      else $error("flash read data is not the low byte");
   property p_direct_done;
      take && i_acc.ofs > 7'h01 |=> o_acc_done && !o_flash_req;
   endproperty
   a_direct_done: assert property (p_direct_done)
      else $error("direct access not done in one cycle");
   property p_bank_write;
      take && i_acc.wr && i_acc.ofs == 7'h08
         |=> o_bank_sel == $past(i_acc.wdata[4:0]);
   endproperty
   a_bank_write: assert property (p_bank_write)
      else $error("bank select did not take the written value");
   property p_bank_hold;
      !take || !i_acc.wr |=> $stable(o_bank_sel);
   endproperty
   a_bank_hold: assert property (p_bank_hold)
      else $error("bank select changed without a write");
   property p_special_zero;
      take && !i_acc.wr && i_acc.ofs >= 7'h0C && i_acc.ofs <= 7'h1F
         |=> o_acc_done && o_acc_rdata == 8'h00;
   endproperty
   a_special_zero: assert property (p_special_zero)
      else $error("special slot read is not zero");
   property p_addr_hold;
      !o_flash_req |-> $stable(o_flash_addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("flash address moved outside a fetch");
   c_flash: cover property (o_flash_req ##1 o_acc_done);
   c_bank: cover property (take && i_acc.wr && i_acc.ofs == 7'h08);
   c_b2b: cover property (o_acc_done ##1 o_acc_done);
endmodule : dmm_addr_map_assertions
bind dmm_addr_map dmm_addr_map_assertions #(.GPR_BANKS(GPR_BANKS)) u_chk (
   .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_acc_req(i_acc_req),
   .i_acc(i_acc), .i_flash_rdata(i_flash_rdata), .o_acc_done(o_acc_done),
   .o_acc_rdata(o_acc_rdata), .o_busy(o_busy), .o_flash_req(o_flash_req),
   .o_flash_addr(o_flash_addr), .o_bank_sel(o_bank_sel));

// ---- testbench/test_dmm_addr_map.sv ----
// Self-checking bench for the data memory address map.
// Assumes the flash model answers fetches; RAM is mirrored here.
`timescale 1ns/1ps
module test_dmm_addr_map;
   localparam int NB = 3;
   logic i_sys_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_acc_req = 1'b0;
   dmm_pkg::dmm_req_t i_acc = '0;
   logic [13:0] flash_w;
   logic o_acc_done, o_busy, o_flash_req;
   logic [7:0] o_acc_rdata;
   logic [14:0] o_flash_addr;
   logic [4:0] o_bank_sel;
   logic [7:0] ram [NB*80];
   logic [7:0] com [16];
   logic [15:0] ptr [2] = '{16'h0000, 16'h0000};
   logic [4:0] bank = 5'h00;
   logic [7:0] expq [$];
   logic [16:0] lfsr = 17'h101BA;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   logic [6:0] tab [5] = '{7'h20, 7'h6F, 7'h70, 7'h15, 7'h02};
   logic [16:0] ptab [12] = '{17'h0204F, 17'h02050, 17'h120A0, 17'h00120,
      17'h029AF, 17'h029B0, 17'h001F0, 17'h08123, 17'h18123, 17'h08123,
      17'h01000, 17'h0FFFF};
   always #2 i_sys_clk = ~i_sys_clk;
   dmm_addr_map #(.GPR_BANKS(NB)) dut (.i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b), .i_acc_req(i_acc_req), .i_acc(i_acc),
      .i_flash_rdata(flash_w), .o_acc_done(o_acc_done),
      .o_acc_rdata(o_acc_rdata), .o_busy(o_busy), .o_flash_req(o_flash_req),
      .o_flash_addr(o_flash_addr), .o_bank_sel(o_bank_sel));
   dmm_flash_model u_flash (.i_sys_clk(i_sys_clk), .i_req(o_flash_req),
      .i_addr(o_flash_addr), .o_rdata(flash_w));
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
      return lfsr[7:0];
   endfunction : rnd
   // Mirror of the decode; writes other than to flash update the mirror and answer zero.
   function automatic logic [7:0] mem(input logic [15:0] a, input logic w,
      input logic [7:0] d);
      int i;
      i = -1;
      if (a >= 16'h2000 && a <= 16'h29AF) i = a - 16'h2000;
      else if (a < 16'h1000 && a[6:0] >= 7'h20 && a[6:0] < 7'h70)
         i = a[11:7] * 80 + a[6:0] - 32;
      if (a < 16'h1000 && a[6:0] >= 7'h70)
      begin
         if (w) com[a[3:0]] = d;
         return w ? 8'h00 : com[a[3:0]];
      end
      // A flash write is dropped but still answers with the fetched byte.
      if (a[15]) return a[7:0] ^ 8'h5C;
      if (i < 0 || i >= NB * 80) return 8'h00;
      if (w) ram[i] = d;
      return w ? 8'h00 : ram[i];
   endfunction : mem
   // One access; a flash access leaves one idle cycle behind it.
   task automatic acc(input logic w, input logic [6:0] o,
      input logic [7:0] d);
      logic [15:0] a;
      logic [7:0] e;
      a = (o <= 7'h01) ? ptr[o[0]] : {4'h0, bank, o};
      e = 8'h00;
      if (o >= 7'h04 && o <= 7'h07)
      begin
         if (w && o[0]) ptr[o[1]][15:8] = d;
         else if (w) ptr[o[1]][7:0] = d;
         else e = o[0] ? ptr[o[1]][15:8] : ptr[o[1]][7:0];
      end
      else if (o == 7'h08 && w) bank = d[4:0];
      else if (o == 7'h08) e = {3'h0, bank};
      else if (o <= 7'h01 || o >= 7'h20) e = mem(a, w, d);
      @(posedge i_sys_clk);
      i_acc_req <= 1'b1;
      i_acc <= '{w, o, d};
      expq.push_back(e);
      if (a[15] && o <= 7'h01)
      begin
         @(posedge i_sys_clk);
         i_acc_req <= 1'b0;
      end
   endtask : acc
   task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: want %h got %h", $time, exp, got);
      end
   endtask : cmp8
   task automatic final_report;
      cmp8(8'(bank), 8'(o_bank_sel));
      if (expq.size() != 0) err_total++;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   // Every done takes the oldest expectation; a missing one is a fault.
   always @(posedge i_sys_clk)
   begin
      cyc <= cyc + 1;
      if (i_rst_b && o_acc_done === 1'b1 && expq.size() == 0)
      begin
         err_total++;
         $display("unexpected done at %0t: want %h got %h", $time, 1'b0,
            o_acc_done);
      end
      else if (i_rst_b && o_acc_done === 1'b1)
         cmp8(expq.pop_front(), o_acc_rdata);
      if (cyc == 3000)
      begin
         err_total++;
         final_report();
      end
   end
   initial
   begin
      repeat (3) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      for (int o = 4; o <= 8; o++) acc(1'b0, 7'(o), 8'h00);
      // Fill every RAM and common byte first, so no read sees an unknown.
      for (int b = 0; b < NB; b++)
      begin
         acc(1'b1, 7'h08, 8'(b));
         for (int o = 32; o < 128; o++) acc(1'b1, 7'(o), rnd());
      end
      for (int b = 0; b < 8; b++)
      begin
         acc(1'b1, 7'h08, 8'(b % 4) | 8'hE0);
         for (int k = 0; k < 5; k++) acc(b > 3, tab[k], rnd());
      end
      for (int i = 0; i < 12; i++)
      begin
         acc(1'b1, 7'(4 + 2 * (i % 2)), ptab[i][7:0]);
         acc(1'b1, 7'(5 + 2 * (i % 2)), ptab[i][15:8]);
         acc(ptab[i][16], 7'(i % 2), rnd());
      end
      for (int i = 0; i < 60; i++)
      begin
         lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
         acc(lfsr[8], (lfsr[6:0] <= 7'h01) ? 7'h20 : lfsr[6:0],
            rnd());
      end
      @(posedge i_sys_clk);
      i_acc_req <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      final_report();
   end
endmodule : test_dmm_addr_map
